/* File: bench/jsbm_probe.sv */
/*
  jtag probe model: tap navigation and lsb-first scans.
  assumes clk paces tck at 16 clk a period; tck stands still between scans.
*/
`default_nettype none
module jsbm_probe (
  input  wire logic clk,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one tck period, tdo taken before the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (8) @(posedge clk);
    #1 o = tdo;
    tck = 1'b1;
    repeat (8) @(posedge clk);
    #1 tck = 1'b0;
  endtask
  // five ones reach test-logic-reset, then idle
  task automatic tap_reset();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  // scan from idle back to idle, tdi left inverted afterwards
  task automatic scan(input logic ir, input int n, input logic [38:0] din, output logic [38:0] dout);
    logic o;
    int   i;
    dout = '0;
    tick(1'b1, 1'b0, o);
    if (ir) begin
      tick(1'b1, 1'b0, o);
    end
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
    end
    tick(1'b1, ~din[n-1], o);
    tick(1'b0, ~din[n-1], o);
  endtask
endmodule
`default_nettype wire

/* File: bench/jsbm_top_checker.sv */
/*
  concurrent checks on service bus and status outputs of jsbm_top.
  assumes one clock domain: clk with asynchronous active-low rst_b.
*/
`default_nettype none
module jsbm_top_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        tdi,
  input wire logic        tdo,
  input wire logic        tdo_oe,
  input wire logic        sb_req,
  input wire logic        sb_dbg,
  input wire logic        sb_wr,
  input wire logic [1:0]  sb_size,
  input wire logic [35:0] sb_addr,
  input wire logic [31:0] sb_wdata,
  input wire logic        sb_abort,
  input wire logic        sb_ack,
  input wire logic        sb_err,
  input wire logic [31:0] sb_rdata,
  input wire logic        flash_rst,
  input wire logic        sec_valid,
  input wire logic        sec_bit,
  input wire logic        busy,
  input wire logic        error,
  input wire logic        prot
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  AST_PROT: assert property ($past(rst_b) |-> prot == $past(flash_rst | ~sec_valid | sec_bit))
    else $error("prot not following status inputs");
  AST_REQ_HOLD: assert property (sb_req && !sb_ack |=> sb_abort || (sb_req && $stable(sb_addr) && $stable(sb_wr)))
    else $error("request changed before acknowledge");
  AST_ACK_DROP: assert property (sb_req && sb_ack |=> !sb_req && !busy ##1 !sb_req)
    else $error("request or busy not released after acknowledge");
  AST_ERR_UPD: assert property (sb_req && sb_ack |=> error == $past(sb_err))
    else $error("error not taken from completion");
  AST_REQ_BUSY: assert property (sb_req |-> busy)
    else $error("request without busy");
  AST_ERR_CLR: assert property ($rose(sb_req) |-> !error)
    else $error("error not cleared at access start");
  AST_ABORT_PULSE: assert property (sb_abort |=> !sb_abort)
    else $error("abort longer than one cycle");
  AST_ABORT_IDLE: assert property (sb_abort |-> ##[0:1] (!sb_req && !busy))
    else $error("abort left bus busy");
  cover property (sb_req && sb_ack && sb_wr);
  cover property (sb_req && sb_ack && !sb_wr);
  cover property (sb_req && sb_ack && sb_err);
  cover property (sb_abort);
endmodule
bind jsbm_top jsbm_top_checker i_chk (
  .clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
  .sb_req(sb_req), .sb_dbg(sb_dbg), .sb_wr(sb_wr), .sb_size(sb_size), .sb_addr(sb_addr),
  .sb_wdata(sb_wdata), .sb_abort(sb_abort), .sb_ack(sb_ack), .sb_err(sb_err), .sb_rdata(sb_rdata),
  .flash_rst(flash_rst), .sec_valid(sec_valid), .sec_bit(sec_bit), .busy(busy), .error(error), .prot(prot)
);
`default_nettype wire

/* File: bench/jsbm_top_tb.sv */
/*
  self-checking bench of jsbm_top with probe model and a stalling bus slave.
  assumes the checker is bound in from its own file.
*/
`default_nettype none
module jsbm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, tck, tms, tdi, tdo, tdo_oe, sb_req, sb_dbg, sb_wr, sb_abort, busy, error, prot;
  logic        rst_b = 1'b0, sb_ack = 1'b0, sb_err = 1'b0, err_on = 1'b0, aborted = 1'b0;
  logic        flash_rst = 1'b0, sec_valid = 1'b1, sec_bit = 1'b0, s_wr, s_dbg, oe_seen = 1'b0;
  logic [1:0]  sb_size, s_size;
  logic [35:0] sb_addr, s_addr;
  logic [31:0] sb_wdata, s_wdata, sb_rdata = 32'h0;
  logic [38:0] cap;
  int          miscompares = 0, n_tests = 0, lat = 2, cnt = 0, cycles = 0;
  jsbm_top i_dut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .sb_req(sb_req), .sb_dbg(sb_dbg), .sb_wr(sb_wr), .sb_size(sb_size), .sb_addr(sb_addr), .sb_wdata(sb_wdata),
    .sb_abort(sb_abort), .sb_ack(sb_ack), .sb_err(sb_err), .sb_rdata(sb_rdata), .flash_rst(flash_rst),
    .sec_valid(sec_valid), .sec_bit(sec_bit), .busy(busy), .error(error), .prot(prot));
  jsbm_probe i_probe (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  // bus slave: answers after lat clk, stalls when lat is large
  always @(posedge clk) begin
    sb_ack <= 1'b0;
    sb_rdata <= ~sb_rdata;
    cnt <= (sb_req && !sb_ack) ? cnt + 1 : 0;
    if (sb_abort) aborted <= 1'b1;
    if (sb_req && !sb_ack && cnt >= lat) begin
      sb_ack <= 1'b1;
      sb_err <= err_on;
      sb_rdata <= sb_addr[31:0] ^ 32'h5A5A_5A5A;
      {s_addr, s_wr, s_size, s_dbg, s_wdata} <= {sb_addr, sb_wr, sb_size, sb_dbg, sb_wdata};
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (tdo_oe) oe_seen <= 1'b1;
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic ir(input logic [4:0] op);
    i_probe.scan(1'b1, 5, {34'h0, op}, cap);
  endtask
  task automatic dr(input int n, input logic [38:0] din);
    i_probe.scan(1'b0, n, din, cap);
  endtask
  task automatic settle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) miscompares++;
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("reset state", {busy, error, prot, sb_req, sb_size, tdo_oe}, 7'h34);
  endtask
  task automatic t_capture();
    ir(5'h11);
    chk("ir capture", cap[4:0], 5'h09);
    chk("tdo enable", {oe_seen, tdo_oe}, 2'b10);
  endtask
  task automatic t_write();
    int i;
    dr(37, {36'h8_1234_5670, 1'b0});
    dr(34, {32'hC0DE_F00D, 2'b00});
    settle();
    chk("word write", {s_wr, s_size, s_addr}, {3'b110, 36'h8_1234_5670});
    chk("write data", s_wdata, 32'hC0DE_F00D);
    ir(5'h12);
    for (i = 1; i < 3; i++) begin
      dr(34, {32'h1111_0000 + i, 2'b00});
      settle();
      chk("block write", {s_wr, s_addr, s_wdata}, {1'b1, 36'h8_1234_5670 + 4 * i, 32'h1111_0000 + i});
    end
  endtask
  task automatic t_read();
    ir(5'h11);
    dr(37, {36'h0_0000_0100, 1'b1});
    settle();
    chk("word read", {s_wr, s_addr}, {1'b0, 36'h0_0000_0100});
    dr(34, 39'h0);
    chk("read data", cap[33:0], {32'h5A5A_5B5A, 2'b00});
  endtask
  task automatic t_error();
    err_on = 1'b1;
    dr(37, {36'h0_0000_0400, 1'b1});
    settle();
    err_on = 1'b0;
    dr(34, 39'h0);
    chk("error on data", cap[1:0], 2'b10);
    dr(37, {36'h0_0000_0500, 1'b1});
    chk("error on address", cap[1], 1'b1);
    settle();
    chk("read after error", {error, s_addr}, {1'b0, 36'h0_0000_0500});
    dr(34, 39'h0);
    ir(5'h12);
    settle();
    chk("block read on ir", {s_wr, s_addr}, {1'b0, 36'h0_0000_0504});
    dr(34, 39'h0);
    chk("block read data", cap[33:0], {32'h5A5A_5F5E, 2'b00});
    settle();
    chk("block next read", s_addr, 36'h0_0000_0508);
  endtask
  task automatic t_sized();
    int i;
    ir(5'h15);
    for (i = 0; i < 3; i++) begin
      dr(39, {36'hF_0000_0010 + i, i[1:0], 1'b1});
      settle();
      chk("sized read", {s_size, s_addr}, {i[1:0], 36'hF_0000_0010 + i});
      dr(34, 39'h0);
    end
  endtask
  task automatic t_debug();
    ir(5'h10);
    dr(8, {7'h45, 1'b1});
    settle();
    chk("debug read", {s_dbg, s_addr}, {1'b1, 36'h0_0000_0045});
    dr(34, 39'h0);
  endtask
  task automatic t_sync();
    ir(5'h17);
    dr(16, 39'h20);
    chk("sync busy", busy, 1'b1);
    repeat (40) @(posedge clk);
    #1 chk("sync done", busy, 1'b0);
  endtask
  task automatic t_bypass();
    logic [4:0] ops [4] = '{5'h1F, 5'h01, 5'h14, 5'h00};
    int         i;
    for (i = 0; i < 4; i++) begin
      ir(ops[i]);
      dr(2, 39'h1);
      chk("bypass", cap[1:0], 2'b10);
    end
  endtask
  task automatic t_prot();
    logic [2:0] c [3] = '{3'b110, 3'b000, 3'b011};
    int         i;
    for (i = 0; i < 3; i++) begin
      {flash_rst, sec_valid, sec_bit} = c[i];
      ir(5'h1F);
      chk("protected", {cap[4], prot}, 2'b11);
    end
    {flash_rst, sec_valid, sec_bit} = 3'b010;
    repeat (3) @(posedge clk);
    #1 chk("unprotected", prot, 1'b0);
  endtask
  task automatic t_cancel();
    lat = 100000;
    ir(5'h11);
    dr(37, {36'h0_0000_0200, 1'b0});
    dr(34, {32'hDEAD_0001, 2'b00});
    dr(37, {36'h0_0000_0300, 1'b1});
    chk("address while busy", cap[0], 1'b1);
    lat = 2;
    settle();
    chk("write under stall", {s_wr, s_addr, s_wdata}, {1'b1, 36'h0_0000_0200, 32'hDEAD_0001});
    dr(37, {36'h0_0000_0300, 1'b1});
    settle();
    chk("address repeated", {s_wr, s_addr}, {1'b0, 36'h0_0000_0300});
    dr(34, 39'h0);
    lat = 100000;
    dr(37, {36'h0_0000_0400, 1'b1});
    dr(34, 39'h0);
    chk("data while busy", cap[0], 1'b1);
    ir(5'h13);
    chk("ir while busy", cap[2], 1'b1);
    chk("cancel", {aborted, busy, error, sb_req}, 4'b1010);
    lat = 2;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 t_reset();
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1 i_probe.tap_reset();
    t_capture();
    t_write();
    t_read();
    t_error();
    t_sized();
    t_debug();
    t_sync();
    t_bypass();
    t_prot();
    t_cancel();
    close_out();
  end
endmodule
`default_nettype wire

/* File: src/jsbm_regs.vh */
/*
  constants of the test-port to service-bus master: opcodes, scan lengths,
  request word layout, status reset values.
  assumes inclusion by src/jsbm_top.v only.
*/
`ifndef JSBM_REGS_VH
`define JSBM_REGS_VH
`define JSBM_IR_W        5
`define JSBM_OP_NEXUS    5'h10
`define JSBM_OP_WORD     5'h11
`define JSBM_OP_BLOCK    5'h12
`define JSBM_OP_CANCEL   5'h13
`define JSBM_OP_SIZED    5'h15
`define JSBM_OP_SYNC     5'h17
`define JSBM_OP_BYPASS   5'h1F
`define JSBM_IR_CAP_LO   2'h1
`define JSBM_SR_W        39
`define JSBM_LEN_W       6
`define JSBM_LEN_WORD    6'h25
`define JSBM_LEN_SIZED   6'h27
`define JSBM_LEN_NEXUS   6'h08
`define JSBM_LEN_DATA    6'h22
`define JSBM_LEN_SYNC    6'h10
`define JSBM_LEN_BYP     6'h01
`define JSBM_ADDR_W      36
`define JSBM_DBG_AW      7
`define JSBM_DATA_W      32
`define JSBM_CNT_W       16
`define JSBM_SIZE_WORD   2'h2
`define JSBM_REQ_W       72
`define JSBM_REQ_DBG     71
`define JSBM_REQ_WR      70
`define JSBM_REQ_SZ_HI   69
`define JSBM_REQ_SZ_LO   68
`define JSBM_REQ_AD_HI   67
`define JSBM_REQ_AD_LO   32
`define JSBM_FIFO_DEPTH  16
`define JSBM_FIFO_AW     4
`define JSBM_ERR_RST     1'b1
`endif

/* File: src/jsbm_top.v */
/*
  test access port bridge onto the service bus, plus its request fifo.
  assumes tck/tms/tdi come from a probe asynchronous to clk, and that
  service bus slaves and flash status share clk.
*/
`default_nettype none
`include "jsbm_regs.vh"

////////////////////////////////////////////////////////////////////////////
module jsbm_fifo #(
  parameter W  = 72,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         flush,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rp_r];

  always @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push & ~pop) cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module jsbm_top (
  input  wire                      clk,
  input  wire                      rst_b,
  input  wire                      tck,
  input  wire                      tms,
  input  wire                      tdi,
  output reg                       tdo,
  output reg                       tdo_oe,
  output reg                       sb_req,
  output reg                       sb_dbg,
  output reg                       sb_wr,
  output reg [1:0]                 sb_size,
  output reg [`JSBM_ADDR_W-1:0]    sb_addr,
  output reg [`JSBM_DATA_W-1:0]    sb_wdata,
  output reg                       sb_abort,
  input  wire                      sb_ack,
  input  wire                      sb_err,
  input  wire [`JSBM_DATA_W-1:0]   sb_rdata,
  input  wire                      flash_rst,
  input  wire                      sec_valid,
  input  wire                      sec_bit,
  output reg                       busy,
  output reg                       error,
  output reg                       prot
);
  localparam S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2, S_CDR = 4'h3;
  localparam S_SHD = 4'h4, S_E1D = 4'h5, S_PD  = 4'h6, S_E2D = 4'h7;
  localparam S_UDR = 4'h8, S_SIR = 4'h9, S_CIR = 4'hA, S_SHI = 4'hB;
  localparam S_E1I = 4'hC, S_PI  = 4'hD, S_E2I = 4'hE, S_UIR = 4'hF;

  reg                      tck_s1_r, tck_s2_r, tck_d_r;
  reg                      tms_s1_r, tms_s2_r;
  reg                      tdi_s1_r, tdi_s2_r;
  reg [3:0]                st_r;
  reg [3:0]                st_nxt;
  reg [`JSBM_IR_W-1:0]     ir_r;
  reg [`JSBM_IR_W-1:0]     ir_sr_r;
  reg [`JSBM_SR_W-1:0]     sr_r;
  reg                      mode_data_r;
  reg [`JSBM_ADDR_W-1:0]   addr_r;
  reg [1:0]                size_r;
  reg                      rd_r;
  reg                      dbg_r;
  reg                      data_seen_r;
  reg                      cap_busy_r;
  reg [`JSBM_DATA_W-1:0]   rdata_r;
  reg [`JSBM_CNT_W-1:0]    sync_cnt_r;
  reg                      push_r;
  reg [`JSBM_REQ_W-1:0]    push_d_r;
  reg                      flush_r;
  reg [`JSBM_LEN_W-1:0]    dr_len;
  reg [`JSBM_ADDR_W-1:0]   n_addr;
  reg [1:0]                n_size;
  reg                      n_dbg;
  reg                      is_mem;
  wire                     tck_rise, tck_fall;
  wire [`JSBM_SR_W-1:0]    al;
  wire                     ign;
  wire [`JSBM_ADDR_W-1:0]  incr;
  wire                     f_in_ready, f_out_valid, f_out_ready;
  wire [`JSBM_REQ_W-1:0]   f_out_data;

  ////////////////////////////////////////////////////////////////////////
  // pin resampling and test clock edges
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_d_r  <= 1'b0;
      tms_s1_r <= 1'b1;
      tms_s2_r <= 1'b1;
      tdi_s1_r <= 1'b0;
      tdi_s2_r <= 1'b0;
    end else begin
      tck_s1_r <= tck;
      tck_s2_r <= tck_s1_r;
      tck_d_r  <= tck_s2_r;
      tms_s1_r <= tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= tdi;
      tdi_s2_r <= tdi_s1_r;
    end
  end

  assign tck_rise = tck_s2_r & ~tck_d_r;
  assign tck_fall = ~tck_s2_r & tck_d_r;

  ////////////////////////////////////////////////////////////////////////
  // tap sequencing
  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_TLR: st_nxt = tms_s2_r ? S_TLR : S_RTI;
      S_RTI: st_nxt = tms_s2_r ? S_SDR : S_RTI;
      S_SDR: st_nxt = tms_s2_r ? S_SIR : S_CDR;
      S_CDR: st_nxt = tms_s2_r ? S_E1D : S_SHD;
      S_SHD: st_nxt = tms_s2_r ? S_E1D : S_SHD;
      S_E1D: st_nxt = tms_s2_r ? S_UDR : S_PD;
      S_PD:  st_nxt = tms_s2_r ? S_E2D : S_PD;
      S_E2D: st_nxt = tms_s2_r ? S_UDR : S_SHD;
      S_UDR: st_nxt = tms_s2_r ? S_SDR : S_RTI;
      S_SIR: st_nxt = tms_s2_r ? S_TLR : S_CIR;
      S_CIR: st_nxt = tms_s2_r ? S_E1I : S_SHI;
      S_SHI: st_nxt = tms_s2_r ? S_E1I : S_SHI;
      S_E1I: st_nxt = tms_s2_r ? S_UIR : S_PI;
      S_PI:  st_nxt = tms_s2_r ? S_E2I : S_PI;
      S_E2I: st_nxt = tms_s2_r ? S_UIR : S_SHI;
      default: st_nxt = tms_s2_r ? S_SDR : S_RTI;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // scan length and address decode per instruction
  always @* begin
    is_mem = 1'b1;
    dr_len = `JSBM_LEN_BYP;
    n_addr = al[`JSBM_ADDR_W:1];
    n_size = `JSBM_SIZE_WORD;
    n_dbg  = 1'b0;
    case (ir_r)
      `JSBM_OP_NEXUS: begin
        dr_len = mode_data_r ? `JSBM_LEN_DATA : `JSBM_LEN_NEXUS;
        n_addr = {{(`JSBM_ADDR_W-`JSBM_DBG_AW){1'b0}}, al[`JSBM_DBG_AW:1]};
        n_dbg  = 1'b1;
      end
      `JSBM_OP_WORD: begin
        dr_len = mode_data_r ? `JSBM_LEN_DATA : `JSBM_LEN_WORD;
      end
      `JSBM_OP_SIZED: begin
        dr_len = mode_data_r ? `JSBM_LEN_DATA : `JSBM_LEN_SIZED;
        n_addr = al[`JSBM_ADDR_W+2:3];
        n_size = al[2:1];
      end
      `JSBM_OP_BLOCK: begin
        is_mem = 1'b0;
        dr_len = `JSBM_LEN_DATA;
      end
      `JSBM_OP_SYNC: begin
        is_mem = 1'b0;
        dr_len = `JSBM_LEN_SYNC;
      end
      default: begin
        is_mem = 1'b0;
        dr_len = `JSBM_LEN_BYP;
      end
    endcase
  end

  assign al   = sr_r >> (`JSBM_SR_W - dr_len);
  assign ign  = cap_busy_r | busy | ~f_in_ready;
  assign incr = {{(`JSBM_ADDR_W-1){1'b0}}, 1'b1} << size_r;
  assign f_out_ready = ~sb_req;

  ////////////////////////////////////////////////////////////////////////
  // scan registers, access control and service bus master
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r        <= S_TLR;
      ir_r        <= `JSBM_OP_BYPASS;
      ir_sr_r     <= {`JSBM_IR_W{1'b0}};
      sr_r        <= {`JSBM_SR_W{1'b0}};
      mode_data_r <= 1'b0;
      addr_r      <= {`JSBM_ADDR_W{1'b0}};
      size_r      <= `JSBM_SIZE_WORD;
      rd_r        <= 1'b0;
      dbg_r       <= 1'b0;
      data_seen_r <= 1'b0;
      cap_busy_r  <= 1'b0;
      rdata_r     <= {`JSBM_DATA_W{1'b0}};
      sync_cnt_r  <= {`JSBM_CNT_W{1'b0}};
      push_r      <= 1'b0;
      push_d_r    <= {`JSBM_REQ_W{1'b0}};
      flush_r     <= 1'b0;
      tdo         <= 1'b0;
      tdo_oe      <= 1'b0;
      sb_req      <= 1'b0;
      sb_dbg      <= 1'b0;
      sb_wr       <= 1'b0;
      sb_size     <= `JSBM_SIZE_WORD;
      sb_addr     <= {`JSBM_ADDR_W{1'b0}};
      sb_wdata    <= {`JSBM_DATA_W{1'b0}};
      sb_abort    <= 1'b0;
      busy        <= 1'b0;
      error       <= `JSBM_ERR_RST;
      prot        <= 1'b1;
    end else begin
      push_r   <= 1'b0;
      flush_r  <= 1'b0;
      sb_abort <= 1'b0;
      prot     <= flash_rst | ~sec_valid | sec_bit;
      // bus side: issue queued request, collect completion
      if (sb_req && sb_ack) begin
        sb_req <= 1'b0;
        busy   <= 1'b0;
        error  <= sb_err;
        if (!sb_wr) rdata_r <= sb_rdata;
      end else if (!sb_req && f_out_valid && !flush_r) begin
        sb_req   <= 1'b1;
        sb_dbg   <= f_out_data[`JSBM_REQ_DBG];
        sb_wr    <= f_out_data[`JSBM_REQ_WR];
        sb_size  <= f_out_data[`JSBM_REQ_SZ_HI:`JSBM_REQ_SZ_LO];
        sb_addr  <= f_out_data[`JSBM_REQ_AD_HI:`JSBM_REQ_AD_LO];
        sb_wdata <= f_out_data[`JSBM_DATA_W-1:0];
      end
      if (sync_cnt_r != {`JSBM_CNT_W{1'b0}}) begin
        sync_cnt_r <= sync_cnt_r - 1'b1;
        if (sync_cnt_r == {{(`JSBM_CNT_W-1){1'b0}}, 1'b1}) busy <= 1'b0;
      end
      if (tck_fall) begin
        tdo_oe <= (st_r == S_SHD) || (st_r == S_SHI);
        tdo    <= (st_r == S_SHI) ? ir_sr_r[0] : sr_r[0];
      end
      if (tck_rise) begin
        st_r <= st_nxt;
        case (st_r)
          S_TLR: begin
            ir_r        <= `JSBM_OP_BYPASS;
            mode_data_r <= 1'b0;
          end
          S_CIR: ir_sr_r <= {prot, error, busy, `JSBM_IR_CAP_LO};
          S_SHI: ir_sr_r <= {tdi_s2_r, ir_sr_r[`JSBM_IR_W-1:1]};
          S_UIR: begin
            ir_r <= ir_sr_r;
            if (ir_sr_r == `JSBM_OP_CANCEL) begin
              sb_req     <= 1'b0;
              sb_abort   <= 1'b1;
              flush_r    <= 1'b1;
              sync_cnt_r <= {`JSBM_CNT_W{1'b0}};
              busy       <= 1'b0;
              if (busy) error <= 1'b1;
              mode_data_r <= 1'b0;
            end else if (ir_sr_r == `JSBM_OP_BLOCK && rd_r && data_seen_r && !busy && f_in_ready) begin
              addr_r   <= addr_r + incr;
              push_r   <= 1'b1;
              push_d_r <= {dbg_r, 1'b0, size_r, addr_r + incr, {`JSBM_DATA_W{1'b0}}};
              busy     <= 1'b1;
              error    <= 1'b0;
            end
          end
          S_CDR: begin
            cap_busy_r <= busy;
            if (ir_r == `JSBM_OP_BLOCK || (is_mem && mode_data_r))
              sr_r <= {5'h00, rdata_r, error, busy};
            else if (is_mem || ir_r == `JSBM_OP_SYNC)
              sr_r <= {{(`JSBM_SR_W-3){1'b0}}, prot, error, busy};
            else
              sr_r <= {`JSBM_SR_W{1'b0}};
          end
          S_SHD: sr_r <= (dr_len == `JSBM_LEN_BYP) ? {{(`JSBM_SR_W-1){1'b0}}, tdi_s2_r}
                                                   : {tdi_s2_r, sr_r[`JSBM_SR_W-1:1]};
          S_UDR: begin
            if (is_mem && !ign) begin
              if (!mode_data_r) begin
                addr_r      <= n_addr;
                size_r      <= n_size;
                dbg_r       <= n_dbg;
                rd_r        <= al[0];
                mode_data_r <= 1'b1;
                data_seen_r <= 1'b0;
                if (al[0]) begin
                  push_r   <= 1'b1;
                  push_d_r <= {n_dbg, 1'b0, n_size, n_addr, {`JSBM_DATA_W{1'b0}}};
                  busy     <= 1'b1;
                  error    <= 1'b0;
                end
              end else begin
                mode_data_r <= 1'b0;
                if (rd_r) begin
                  data_seen_r <= 1'b1;
                end else begin
                  push_r   <= 1'b1;
                  push_d_r <= {dbg_r, 1'b1, size_r, addr_r, al[`JSBM_DATA_W+1:2]};
                  busy     <= 1'b1;
                  error    <= 1'b0;
                end
              end
            end else if (ir_r == `JSBM_OP_BLOCK && !ign) begin
              addr_r   <= addr_r + incr;
              push_r   <= 1'b1;
              push_d_r <= {dbg_r, ~rd_r, size_r, addr_r + incr, al[`JSBM_DATA_W+1:2]};
              busy     <= 1'b1;
              error    <= 1'b0;
              if (rd_r) data_seen_r <= 1'b1;
            end else if (ir_r == `JSBM_OP_SYNC && !ign) begin
              sync_cnt_r <= al[`JSBM_CNT_W-1:0];
              if (al[`JSBM_CNT_W-1:0] != {`JSBM_CNT_W{1'b0}}) busy <= 1'b1;
            end
            // busy at capture: address or data dropped, mode kept
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request queue between scan logic and bus
  jsbm_fifo #(
    .W  (`JSBM_REQ_W),
    .D  (`JSBM_FIFO_DEPTH),
    .AW (`JSBM_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (flush_r),
    .in_valid  (push_r),
    .in_ready  (f_in_ready),
    .in_data   (push_d_r),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );
endmodule
`default_nettype wire
